/* rtl/crossbar_allocator.sv */
// Priority allocation of enabled peripheral signals to crossbar pins.
`timescale 1ns/1ps
module crossbar_allocator #(
  parameter int NPINS = crossbar_pkg::NUM_PINS,
  parameter int NSIG = crossbar_pkg::NUM_SIG,
  parameter int SW = crossbar_pkg::SIG_W
) (
  input wire logic [NSIG-1:0] sig_en,
  input wire logic [NPINS-1:0] skip,
  output logic [NPINS-1:0] owned,
  output logic [NPINS-1:0][SW-1:0] owner
);
  import crossbar_pkg::*;

  // Purely combinational, so the map follows every register change at once.
  always_comb
  begin
    logic found;
    logic [5:0] fx;
    owned = '0;
    owner = '0;
    found = 1'b0;
    fx = '0;
    // Fixed signals claim their pins first, independent of skip bits.
    for (int s = 0; s < NSIG; s++)
    begin
      fx = fixed_pin(s);
      if (sig_en[s] && fx[5])
      begin
        owned[fx[4:0]] = 1'b1;
        owner[fx[4:0]] = SW'(s);
      end
    end
    // The rest take the lowest free unskipped pin, in signal order.
    for (int s = 0; s < NSIG; s++)
    begin
      fx = fixed_pin(s);
      found = 1'b0;
      if (sig_en[s] && !fx[5])
      begin
        for (int p = 0; p < NPINS; p++)
        begin
          if (!found && !owned[p] && !skip[p])
          begin
            owned[p] = 1'b1;
            owner[p] = SW'(s);
            found = 1'b1;
          end
        end
      end
    end
  end
endmodule

/* rtl/crossbar_pkg.sv */
// Constants, field layouts and carrier types of the crossbar and port block.
package crossbar_pkg;
  localparam int NUM_PINS = 23;
  localparam int NUM_SIG = 21;
  localparam int SIG_W = 5;
  localparam int PORT1_BASE = 8;
  localparam int PORT2_BASE = 16;
  localparam int P2_PINS = 7;

  localparam logic [7:0] ADDR_P1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_P2_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_P1_DRIVE = 8'hA5;
  localparam logic [7:0] ADDR_P1_SKIP = 8'hD5;
  localparam logic [7:0] ADDR_P2_SKIP = 8'hD6;
  localparam logic [7:0] ADDR_P2_MODE = 8'hF3;
  localparam logic [3:0] PAGE_BASE = 4'h0;
  localparam logic [3:0] PAGE_CONFIG = 4'hF;

  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [6:0] RST_MODE = 7'h7F;
  localparam logic MODE_RESERVED_READ = 1'b1;

  localparam int SEL_A_UART = 0;
  localparam int SEL_A_FIRST_SERIAL_PERIPH = 1;
  localparam int SEL_A_SMBUS = 2;
  localparam int SEL_A_SYSCLK = 3;
  localparam int SEL_A_CP0 = 4;
  localparam int SEL_A_CP0A = 5;
  localparam int SEL_B_PCA_LSB = 0;
  localparam int SEL_B_ECI = 3;
  localparam int SEL_B_T0 = 4;
  localparam int SEL_B_T1 = 5;
  localparam int SEL_C_SECOND_SERIAL_PERIPH = 0;
  localparam int SEL_C_CROSSBAR_ENABLE_BIT = 6;
  localparam logic [1:0] SSM_THREE_WIRE = 2'h0;

  localparam int SIG_UART_TX = 0;
  localparam int SIG_UART_RX = 1;
  localparam int SIG_SECOND_SERIAL_PERIPH_SCK = 2;
  localparam int SIG_SECOND_SERIAL_PERIPH_MISO = 3;
  localparam int SIG_SECOND_SERIAL_PERIPH_MOSI = 4;
  localparam int SIG_SECOND_SERIAL_PERIPH_NSS = 5;
  localparam int SIG_FIRST_SERIAL_PERIPH_SCK = 6;
  localparam int SIG_FIRST_SERIAL_PERIPH_MISO = 7;
  localparam int SIG_FIRST_SERIAL_PERIPH_MOSI = 8;
  localparam int SIG_FIRST_SERIAL_PERIPH_NSS = 9;
  localparam int SIG_SMB_SDA = 10;
  localparam int SIG_SMB_SCL = 11;
  localparam int SIG_CP0 = 12;
  localparam int SIG_CP0A = 13;
  localparam int SIG_SYSCLK = 14;
  localparam int SIG_CEX0 = 15;
  localparam int SIG_ECI = 18;
  localparam int SIG_T0 = 19;
  localparam int SIG_T1 = 20;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_wr;
    logic [7:0] bit_addr;
    logic bit_val;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0] select_a;
    logic [7:0] select_b;
    logic [7:0] select_c;
    logic [1:0] slave_select_mode_bits;
    logic second_four_wire;
  } xbar_cfg_t;

  typedef struct packed {
    logic [7:0] p1_latch;
    logic [7:0] p2_latch;
    logic [7:0] p1_drive;
    logic [7:0] p1_skip;
    logic [7:0] p2_skip;
    logic [6:0] p2_mode;
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic [NUM_SIG-1:0] periph_in;
    logic [7:0] rdata;
  } port_state_t;

  localparam port_state_t ST_RESET = '{p1_latch: RST_LATCH, p2_latch: RST_LATCH, p1_drive: RST_DRIVE,
    p1_skip: RST_SKIP, p2_skip: RST_SKIP, p2_mode: RST_MODE, default: '0};

  // Returns {fixed, pin} for signals tied to one pin.
  function automatic logic [5:0] fixed_pin(input int s);
    case (s)
      SIG_UART_TX: fixed_pin = {1'b1, 5'h04};
      SIG_UART_RX: fixed_pin = {1'b1, 5'h05};
      SIG_SECOND_SERIAL_PERIPH_SCK: fixed_pin = {1'b1, 5'h08};
      SIG_SECOND_SERIAL_PERIPH_MISO: fixed_pin = {1'b1, 5'h09};
      SIG_SECOND_SERIAL_PERIPH_MOSI: fixed_pin = {1'b1, 5'h0A};
      SIG_SECOND_SERIAL_PERIPH_NSS: fixed_pin = {1'b1, 5'h0B};
      default: fixed_pin = 6'h00;
    endcase
  endfunction
endpackage

/* rtl/priority_crossbar_port_io.sv */
// Crossbar decoder with port 1 and port 2 registers and pin drivers.
// Behaviour
// - Selected peripheral functions reach pins in fixed priority order.
// - Only non-fixed functions need skip bit zero; fixed pins are taken regardless of skip.
// - Primary serial port, highest priority, gets pins P0.4 and P0.5.
// - Second serial interface comes next and gets P1.0 to P1.2.
// - Second serial interface in four-wire mode also gets P1.3.
// - Other functions take lowest free unskipped pins in descending priority.
// - Taken or skipped pins are passed over for the next free pin.
// - Output drivers stay off while crossbar enable is zero.
// - Routed SMBus pins are forced open-drain regardless of output mode.
// - First serial interface slave select is routed only in four-wire mode.
// - First serial interface wire mode shifts all lower priority pins.
// - Port write sets the latch; port read returns the pin level.
// - Port 1 data is bit addressable at 0x90 and resets to all ones.
// - Skip bit one excludes the pin from non-fixed functions; zero leaves it available.
// - Drive bit one selects high drive; zero selects low drive.
// - Port 2 mode bit zero disables pull-up and receiver, not driver.
// - Port 2 mode top bit reads one; software writes it one.
`timescale 1ns/1ps
module priority_crossbar_port_io (
  input wire logic clk,
  input wire logic rst_b,
  input wire crossbar_pkg::sfr_req_t sfr,
  input wire crossbar_pkg::xbar_cfg_t cfg,
  input wire logic [7:0] port0_latch,
  input wire logic [7:0] port0_skip,
  input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_output_mode,
  input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [crossbar_pkg::NUM_SIG-1:0] periph_out,
  input wire logic [crossbar_pkg::NUM_SIG-1:0] periph_oe,
  output logic [crossbar_pkg::NUM_PINS-1:0] pin_out,
  output logic [crossbar_pkg::NUM_PINS-1:0] pin_oe,
  output logic [crossbar_pkg::NUM_SIG-1:0] periph_in,
  output logic [7:0] p1_drive_high,
  output logic [6:0] p2_pullup_en,
  output logic [7:0] sfr_rdata
);
  import crossbar_pkg::*;

  logic [1:0] rst_sync;
  logic rst_n;
  port_state_t st;
  port_state_t nx;
  logic [NUM_SIG-1:0] sig_en;
  logic [NUM_PINS-1:0] skip_vec;
  logic [NUM_PINS-1:0] owned;
  logic [NUM_PINS-1:0][SIG_W-1:0] owner;
  logic [NUM_PINS-1:0] live;
  logic [NUM_PINS-1:0] gpio_val;
  logic xbar_on;
  logic first_serial_periph_four;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  assign xbar_on = cfg.select_c[SEL_C_CROSSBAR_ENABLE_BIT];
  assign first_serial_periph_four = cfg.slave_select_mode_bits != SSM_THREE_WIRE;
  assign skip_vec = {st.p2_skip[P2_PINS-1:0], st.p1_skip, port0_skip};
  assign gpio_val = {st.p2_latch[P2_PINS-1:0], st.p1_latch, port0_latch};
  // Analog port 2 pins have their digital receiver off and read low.
  assign live = st.pin_level & {st.p2_mode, {PORT2_BASE{1'b1}}};

  // Signal enables follow the current select and mode settings.
  always_comb
  begin
    sig_en = '0;
    sig_en[SIG_UART_TX] = cfg.select_a[SEL_A_UART];
    sig_en[SIG_UART_RX] = cfg.select_a[SEL_A_UART];
    sig_en[SIG_SECOND_SERIAL_PERIPH_SCK] = cfg.select_c[SEL_C_SECOND_SERIAL_PERIPH];
    sig_en[SIG_SECOND_SERIAL_PERIPH_MISO] = cfg.select_c[SEL_C_SECOND_SERIAL_PERIPH];
    sig_en[SIG_SECOND_SERIAL_PERIPH_MOSI] = cfg.select_c[SEL_C_SECOND_SERIAL_PERIPH];
    sig_en[SIG_SECOND_SERIAL_PERIPH_NSS] = cfg.select_c[SEL_C_SECOND_SERIAL_PERIPH] & cfg.second_four_wire;
    sig_en[SIG_FIRST_SERIAL_PERIPH_SCK] = cfg.select_a[SEL_A_FIRST_SERIAL_PERIPH];
    sig_en[SIG_FIRST_SERIAL_PERIPH_MISO] = cfg.select_a[SEL_A_FIRST_SERIAL_PERIPH];
    sig_en[SIG_FIRST_SERIAL_PERIPH_MOSI] = cfg.select_a[SEL_A_FIRST_SERIAL_PERIPH];
    sig_en[SIG_FIRST_SERIAL_PERIPH_NSS] = cfg.select_a[SEL_A_FIRST_SERIAL_PERIPH] & first_serial_periph_four;
    sig_en[SIG_SMB_SDA] = cfg.select_a[SEL_A_SMBUS];
    sig_en[SIG_SMB_SCL] = cfg.select_a[SEL_A_SMBUS];
    sig_en[SIG_CP0] = cfg.select_a[SEL_A_CP0];
    sig_en[SIG_CP0A] = cfg.select_a[SEL_A_CP0A];
    sig_en[SIG_SYSCLK] = cfg.select_a[SEL_A_SYSCLK];
    for (int k = 0; k < 3; k++)
      sig_en[SIG_CEX0 + k] = cfg.select_b[SEL_B_PCA_LSB +: 2] > 2'(k);
    sig_en[SIG_ECI] = cfg.select_b[SEL_B_ECI];
    sig_en[SIG_T0] = cfg.select_b[SEL_B_T0];
    sig_en[SIG_T1] = cfg.select_b[SEL_B_T1];
  end

  // Map is rebuilt from live register contents every cycle.
  crossbar_allocator #(
    .NPINS(NUM_PINS),
    .NSIG(NUM_SIG),
    .SW(SIG_W)
  ) u_alloc (
    .sig_en(sig_en),
    .skip(skip_vec),
    .owned(owned),
    .owner(owner)
  );

  always_comb
  begin
    logic od;
    logic val;
    logic drv;
    nx = st;
    od = 1'b0;
    val = 1'b0;
    drv = 1'b0;
    // Pin inputs cross two flip-flops before any use.
    nx.pin_meta = pin_in;
    nx.pin_level = st.pin_meta;
    if (sfr.wr)
    begin
      unique case (sfr.addr)
        ADDR_P1_LATCH: nx.p1_latch = sfr.wdata;
        ADDR_P2_LATCH: nx.p2_latch = sfr.wdata;
        ADDR_P1_DRIVE:
        begin
          if (sfr.page == PAGE_CONFIG)
            nx.p1_drive = sfr.wdata;
        end
        ADDR_P1_SKIP:
        begin
          if (sfr.page == PAGE_BASE)
            nx.p1_skip = sfr.wdata;
        end
        ADDR_P2_SKIP:
        begin
          if (sfr.page == PAGE_BASE)
            nx.p2_skip = sfr.wdata;
        end
        ADDR_P2_MODE:
        begin
          if (sfr.page == PAGE_BASE)
            nx.p2_mode = sfr.wdata[6:0];
        end
        default: nx.p1_latch = st.p1_latch;
      endcase
    end
    // Single-bit writes reach the port latches on every page.
    if (sfr.bit_wr && sfr.bit_addr[7:3] == ADDR_P1_LATCH[7:3])
      nx.p1_latch[sfr.bit_addr[2:0]] = sfr.bit_val;
    if (sfr.bit_wr && sfr.bit_addr[7:3] == ADDR_P2_LATCH[7:3])
      nx.p2_latch[sfr.bit_addr[2:0]] = sfr.bit_val;
    if (sfr.rd)
    begin
      unique case (sfr.addr)
        ADDR_P1_LATCH: nx.rdata = live[PORT1_BASE +: 8];
        ADDR_P2_LATCH: nx.rdata = {st.p2_latch[7], live[PORT2_BASE +: P2_PINS]};
        ADDR_P1_DRIVE: nx.rdata = (sfr.page == PAGE_CONFIG) ? st.p1_drive : 8'h00;
        ADDR_P1_SKIP: nx.rdata = (sfr.page == PAGE_BASE) ? st.p1_skip : 8'h00;
        ADDR_P2_SKIP: nx.rdata = (sfr.page == PAGE_BASE) ? st.p2_skip : 8'h00;
        ADDR_P2_MODE: nx.rdata = (sfr.page == PAGE_BASE) ? {MODE_RESERVED_READ, st.p2_mode} : 8'h00;
        default: nx.rdata = 8'h00;
      endcase
    end
    nx.periph_in = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      if (owned[p])
      begin
        val = periph_out[owner[p]];
        od = !pin_output_mode[p] || owner[p] == SIG_W'(SIG_SMB_SDA) || owner[p] == SIG_W'(SIG_SMB_SCL);
        drv = od ? !val : periph_oe[owner[p]];
        nx.periph_in[owner[p]] = live[p];
      end
      else
      begin
        val = gpio_val[p];
        od = !pin_output_mode[p];
        drv = od ? !val : 1'b1;
      end
      nx.pin_out[p] = od ? 1'b0 : val;
      nx.pin_oe[p] = xbar_on & drv;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= ST_RESET;
    else
      st <= nx;
  end

  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign periph_in = st.periph_in;
  assign p1_drive_high = st.p1_drive;
  assign p2_pullup_en = st.p2_mode;
  assign sfr_rdata = st.rdata;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_drivers_off;
    !cfg.select_c[SEL_C_CROSSBAR_ENABLE_BIT] |=> pin_oe == '0;
  endproperty
  a_drivers_off: assert property (p_drivers_off)
    else $error("pin driver enabled while crossbar is off");

  property p_uart_fixed;
    cfg.select_a[SEL_A_UART] |-> owned[4] && owner[4] == SIG_W'(SIG_UART_TX) && owner[5] == SIG_W'(SIG_UART_RX);
  endproperty
  a_uart_fixed: assert property (p_uart_fixed)
    else $error("primary serial port not on its fixed pins");

  property p_second_serial_periph_fixed;
    cfg.select_c[SEL_C_SECOND_SERIAL_PERIPH] |-> owner[8] == SIG_W'(SIG_SECOND_SERIAL_PERIPH_SCK) && owner[10] == SIG_W'(SIG_SECOND_SERIAL_PERIPH_MOSI);
  endproperty
  a_second_serial_periph_fixed: assert property (p_second_serial_periph_fixed)
    else $error("second serial interface not on its fixed pins");

  property p_second_serial_periph_nss;
    cfg.select_c[SEL_C_SECOND_SERIAL_PERIPH] && cfg.second_four_wire |-> owned[11] && owner[11] == SIG_W'(SIG_SECOND_SERIAL_PERIPH_NSS);
  endproperty
  a_second_serial_periph_nss: assert property (p_second_serial_periph_nss)
    else $error("second serial slave select missing in four-wire mode");

  property p_skip_honoured;
    skip_vec[0] |-> !owned[0];
  endproperty
  a_skip_honoured: assert property (p_skip_honoured)
    else $error("skipped pin was assigned");

  property p_first_free;
    cfg.select_a[SEL_A_FIRST_SERIAL_PERIPH] && !skip_vec[0] |-> owned[0] && owner[0] == SIG_W'(SIG_FIRST_SERIAL_PERIPH_SCK);
  endproperty
  a_first_free: assert property (p_first_free)
    else $error("first non-fixed function not on lowest free pin");

  property p_four_wire_shift;
    cfg.select_a[SEL_A_FIRST_SERIAL_PERIPH] && cfg.select_a[SEL_A_SMBUS] && !cfg.select_a[SEL_A_UART] && skip_vec[4:0] == 5'h00
      && first_serial_periph_four |-> owner[4] == SIG_W'(SIG_SMB_SDA);
  endproperty
  a_four_wire_shift: assert property (p_four_wire_shift)
    else $error("lower priority data line not shifted by slave select");

  property p_three_wire;
    cfg.select_a[SEL_A_FIRST_SERIAL_PERIPH] && cfg.select_a[SEL_A_SMBUS] && !cfg.select_a[SEL_A_UART] && skip_vec[4:0] == 5'h00
      && !first_serial_periph_four |-> owner[3] == SIG_W'(SIG_SMB_SDA);
  endproperty
  a_three_wire: assert property (p_three_wire)
    else $error("slave select routed in three-wire mode");

  property p_smbus_od;
    owned[0] && owner[0] == SIG_W'(SIG_SMB_SDA) |=> !pin_out[0];
  endproperty
  a_smbus_od: assert property (p_smbus_od)
    else $error("data line of SMBus driven high");

  property p_p1_read;
    sfr.rd && sfr.addr == ADDR_P1_LATCH |=> sfr_rdata == $past(pin_in[15:8], 3);
  endproperty
  a_p1_read: assert property (p_p1_read)
    else $error("port 1 read does not return pin level");

  property p_p1_bit;
    sfr.bit_wr && sfr.bit_addr == 8'h93 && !sfr.wr |=> st.p1_latch[3] == $past(sfr.bit_val);
  endproperty
  a_p1_bit: assert property (p_p1_bit)
    else $error("single-bit write to port 1 lost");

  property p_drive_write;
    sfr.wr && sfr.addr == ADDR_P1_DRIVE && sfr.page == PAGE_CONFIG |=> p1_drive_high == $past(sfr.wdata);
  endproperty
  a_drive_write: assert property (p_drive_write)
    else $error("drive strength write not applied");

  property p_reserved_one;
    sfr.rd && sfr.addr == ADDR_P2_MODE && sfr.page == PAGE_BASE |=> sfr_rdata[7];
  endproperty
  a_reserved_one: assert property (p_reserved_one)
    else $error("reserved mode bit read as zero");

  property p_analog_mode;
    sfr.wr && sfr.addr == ADDR_P2_MODE && sfr.page == PAGE_BASE && !sfr.wdata[0] |=> !p2_pullup_en[0] ##2 !live[16];
  endproperty
  a_analog_mode: assert property (p_analog_mode)
    else $error("analog pin kept pull-up or receiver");
endmodule

/* tb/pin_partner.sv */
// Outside circuitry on the port pins: board pull-ups plus optional outside drivers.
`timescale 1ns/1ps
module pin_partner (
  input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [crossbar_pkg::NUM_PINS-1:0] ext_en,
  input wire logic [crossbar_pkg::NUM_PINS-1:0] ext_val,
  output logic [crossbar_pkg::NUM_PINS-1:0] pin_in
);
  import crossbar_pkg::*;
  // A pin that nobody drives is pulled up, so a released open-drain line reads high.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule

/* tb/priority_crossbar_port_io_tb.sv */
// Self-checking bench for the crossbar and port block against an integer model.
`timescale 1ns/1ps
module priority_crossbar_port_io_tb;
  import crossbar_pkg::*;
  logic clk;
  logic rst_b;
  sfr_req_t req;
  xbar_cfg_t cfg;
  logic [7:0] port0_latch;
  logic [7:0] port0_skip;
  logic [NUM_PINS-1:0] pin_output_mode;
  logic [NUM_PINS-1:0] pin_in;
  logic [NUM_SIG-1:0] periph_out;
  logic [NUM_SIG-1:0] periph_oe;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_SIG-1:0] periph_in;
  logic [7:0] p1_drive_high;
  logic [6:0] p2_pullup_en;
  logic [7:0] sfr_rdata;
  logic [NUM_PINS-1:0] ext_en;
  logic [NUM_PINS-1:0] ext_val;
  logic [7:0] lat1;
  logic [7:0] lat2;
  logic [7:0] drv;
  logic [7:0] skip1;
  logic [7:0] skip2;
  logic [6:0] mode;
  int n_fail;
  int compares;

  priority_crossbar_port_io DUT (.clk(clk), .rst_b(rst_b), .sfr(req), .cfg(cfg), .port0_latch(port0_latch),
    .port0_skip(port0_skip), .pin_output_mode(pin_output_mode), .pin_in(pin_in), .periph_out(periph_out),
    .periph_oe(periph_oe), .pin_out(pin_out), .pin_oe(pin_oe), .periph_in(periph_in),
    .p1_drive_high(p1_drive_high), .p2_pullup_en(p2_pullup_en), .sfr_rdata(sfr_rdata));

  pin_partner board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One register access: k 0 byte write, 1 read, 2 bit write; read data is settled on return.
  task automatic acc(input int k, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = '{wr: k == 0, rd: k == 1, page: pg, addr: a, wdata: d, bit_wr: k == 2, bit_addr: a, bit_val: d[0]};
    @(posedge clk);
    #1;
    req = '0;
    @(posedge clk);
    #1;
  endtask

  task automatic check_all();
    int own[NUM_PINS];
    int en[NUM_SIG];
    logic [NUM_PINS-1:0] sk;
    logic [NUM_PINS-1:0] eo;
    logic [NUM_PINS-1:0] ev;
    logic [NUM_PINS-1:0] lv;
    logic [NUM_SIG-1:0] epi;
    int p;
    int s;
    logic v;
    repeat (6) @(posedge clk);
    #1;
    sk = {skip2[6:0], skip1, port0_skip};
    epi = '0;
    for (int i = 0; i < NUM_SIG; i++)
    begin
      en[i] = i < 2 ? cfg.select_a[0] : i < 5 ? cfg.select_c[0] : i == 5 ? cfg.select_c[0] && cfg.second_four_wire
        : i < 9 ? cfg.select_a[1] : i == 9 ? cfg.select_a[1] && cfg.slave_select_mode_bits != 2'h0
        : i < 12 ? cfg.select_a[2] : i == 12 ? cfg.select_a[4] : i == 13 ? cfg.select_a[5]
        : i == 14 ? cfg.select_a[3] : i < 18 ? i - 15 < cfg.select_b[1:0] : cfg.select_b[i - 15];
    end
    for (int i = 0; i < NUM_PINS; i++)
      own[i] = -1;
    for (int i = 0; i < 6; i++)
      if (en[i])
        own[i < 2 ? 4 + i : 6 + i] = i;
    for (s = 6; s < NUM_SIG; s++)
      if (en[s])
      begin
        p = 0;
        while (p < NUM_PINS && (own[p] >= 0 || sk[p]))
          p++;
        if (p < NUM_PINS)
          own[p] = s;
      end
    for (int i = 0; i < NUM_PINS; i++)
    begin
      s = own[i];
      v = s >= 0 ? periph_out[s] : i < 8 ? port0_latch[i] : i < 16 ? lat1[i - 8] : lat2[i - 16];
      if (!pin_output_mode[i] || s == SIG_SMB_SDA || s == SIG_SMB_SCL)
      begin
        eo[i] = !v;
        ev[i] = 1'b0;
      end
      else
      begin
        eo[i] = s >= 0 ? periph_oe[s] : 1'b1;
        ev[i] = v;
      end
      eo[i] = eo[i] && cfg.select_c[SEL_C_CROSSBAR_ENABLE_BIT];
      lv[i] = eo[i] ? ev[i] : ext_en[i] ? ext_val[i] : 1'b1;
      if (i >= PORT2_BASE && !mode[i - PORT2_BASE])
        lv[i] = 1'b0;
      if (s >= 0)
        epi[s] = lv[i];
    end
    chk(pin_oe, eo, "pin enables");
    chk(pin_out & eo, ev & eo, "pin values");
    chk(periph_in, epi, "routed inputs");
    chk(p1_drive_high, drv, "drive out");
    chk(p2_pullup_en, mode, "pull-up out");
    acc(1, PAGE_BASE, ADDR_P1_LATCH, 8'h00);
    chk(sfr_rdata, lv[15:8], "port1 read");
    acc(1, PAGE_CONFIG, ADDR_P2_LATCH, 8'h00);
    chk(sfr_rdata, {lat2[7], lv[22:16]}, "port2 read");
    acc(1, PAGE_CONFIG, ADDR_P1_DRIVE, 8'h00);
    chk(sfr_rdata, drv, "drive read");
    acc(1, PAGE_BASE, ADDR_P1_DRIVE, 8'h00);
    chk(sfr_rdata, 8'h00, "drive other page");
    acc(1, PAGE_BASE, ADDR_P1_SKIP, 8'h00);
    chk(sfr_rdata, skip1, "skip1 read");
    acc(1, PAGE_BASE, ADDR_P2_SKIP, 8'h00);
    chk(sfr_rdata, skip2, "skip2 read");
    acc(1, PAGE_BASE, ADDR_P2_MODE, 8'h00);
    chk(sfr_rdata, {1'b1, mode}, "mode read");
    acc(1, PAGE_BASE, 8'h91, 8'h00);
    chk(sfr_rdata, 8'h00, "unmapped read");
  endtask

  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end

  initial
  begin
    int b;
    logic [7:0] d;
    void'($urandom(32'hDABD));
    n_fail = 0;
    compares = 0;
    req = '0;
    cfg = '0;
    cfg.select_c[SEL_C_CROSSBAR_ENABLE_BIT] = 1'b1;
    port0_latch = 8'h3C;
    port0_skip = 8'h00;
    pin_output_mode = '1;
    periph_out = '0;
    periph_oe = '0;
    ext_en = '0;
    ext_val = '0;
    lat1 = RST_LATCH;
    lat2 = RST_LATCH;
    drv = RST_DRIVE;
    skip1 = RST_SKIP;
    skip2 = RST_SKIP;
    mode = RST_MODE;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    check_all();
    for (int it = 0; it < 60; it++)
    begin
      cfg = $bits(xbar_cfg_t)'($urandom);
      cfg.select_c[SEL_C_CROSSBAR_ENABLE_BIT] = it % 8 != 3;
      port0_latch = 8'($urandom);
      port0_skip = 8'($urandom) & 8'($urandom);
      pin_output_mode = 23'($urandom);
      periph_out = 21'($urandom);
      periph_oe = 21'($urandom);
      ext_en = 23'($urandom);
      ext_val = 23'($urandom);
      lat1 = 8'($urandom);
      acc(0, 4'($urandom), ADDR_P1_LATCH, lat1);
      lat2 = 8'($urandom);
      acc(0, 4'($urandom), ADDR_P2_LATCH, lat2);
      skip1 = 8'($urandom) & 8'($urandom);
      acc(0, PAGE_BASE, ADDR_P1_SKIP, skip1);
      skip2 = 8'($urandom) & 8'($urandom);
      acc(0, PAGE_BASE, ADDR_P2_SKIP, skip2);
      drv = 8'($urandom);
      acc(0, PAGE_CONFIG, ADDR_P1_DRIVE, drv);
      d = 8'($urandom);
      d[7] = 1'b1;
      mode = d[6:0];
      acc(0, PAGE_BASE, ADDR_P2_MODE, d);
      acc(0, PAGE_BASE, ADDR_P1_DRIVE, 8'($urandom));
      acc(0, PAGE_CONFIG, ADDR_P1_SKIP, 8'($urandom));
      acc(0, PAGE_BASE, 8'h91, 8'($urandom));
      b = $urandom % 8;
      d = 8'($urandom);
      acc(2, PAGE_BASE, ADDR_P1_LATCH + 8'(b), d);
      lat1[b] = d[0];
      acc(2, PAGE_BASE, ADDR_P2_LATCH + 8'(b), d);
      lat2[b] = d[0];
      check_all();
    end
    final_report();
  end
endmodule
